// ---- amgc_bank.v ----
// Analog mixer gain control register bank with bus port and field outputs
`timescale 1ns/1ps
`include "amgc_regs.vh"
module amgc_bank (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Power-down pin, active low, from outside
  input wire power_down_pin_b,
  // Register port
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_r,
  // Status
  output reg converter_powered_down_flag_r,
  // ADC right input fields
  output reg right_adc_mic_boost_r,
  output reg [3:0] right_adc_input_gain_r,
  // DAC2 mix fields
  output reg left_dac2_mix_mute_r,
  output reg [4:0] left_dac2_mix_gain_r,
  output reg right_dac2_mix_mute_r,
  output reg [4:0] right_dac2_mix_gain_r,
  // Aux 1 mix fields
  output reg left_aux1_mix_mute_r,
  output reg [4:0] left_aux1_mix_gain_r,
  output reg right_aux1_mix_mute_r,
  output reg [4:0] right_aux1_mix_gain_r,
  // Aux 2 mix fields
  output reg left_aux2_mix_mute_r,
  output reg [4:0] left_aux2_mix_gain_r,
  output reg right_aux2_mix_mute_r,
  output reg [4:0] right_aux2_mix_gain_r,
  // Aux 3 mix fields
  output reg left_aux3_mix_mute_r,
  output reg [4:0] left_aux3_mix_gain_r,
  output reg right_aux3_mix_mute_r,
  output reg [4:0] right_aux3_mix_gain_r,
  // Mic mix fields
  output reg left_mic_mix_mute_r,
  output reg [4:0] left_mic_mix_gain_r,
  output reg right_mic_mix_mute_r,
  output reg [4:0] right_mic_mix_gain_r
);
  wire pin_high;
  wire [15:0] adc_in_val;
  wire [15:0] dac2_val;
  wire [15:0] aux1_val;
  wire [15:0] aux2_val;
  wire [15:0] aux3_val;
  wire [15:0] mic_val;
  reg [15:0] pwr_ctrl_r;
  reg [15:0] pwr_ctrl_nxt;
  reg [15:0] conv_pdn_r;
  reg [15:0] conv_pdn_nxt;
  reg [15:0] rdata_nxt;
  wire pdn_req;
  wire conv_pdn;
  wire dac2_enabled;
  wire analog_mix_enabled;
  wire hold_adc;
  wire hold_dac2;
  wire hold_aux;

  amgc_sync u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(power_down_pin_b),
    .level_r(pin_high)
  );

  // Converter power-down while the pin is low or the request bit is set
  assign pdn_req = conv_pdn_r[`AMGC_CPD_BIT];
  assign conv_pdn = ~pin_high | pdn_req; // R15
  assign dac2_enabled = pwr_ctrl_r[`AMGC_PWR_DDM_BIT] &
    pwr_ctrl_r[`AMGC_PWR_DA2_BIT] & pwr_ctrl_r[`AMGC_PWR_ANA_BIT];
  assign analog_mix_enabled = pwr_ctrl_r[`AMGC_PWR_AAM_BIT] &
    pwr_ctrl_r[`AMGC_PWR_ANA_BIT];
  assign hold_adc = conv_pdn; // R03
  assign hold_dac2 = conv_pdn | ~dac2_enabled; // R06
  assign hold_aux = conv_pdn | ~analog_mix_enabled; // R10 R14

  // The pin low also clears the power control bits it governs
  always @* begin
    pwr_ctrl_nxt = pwr_ctrl_r;
    conv_pdn_nxt = conv_pdn_r;
    if (!pin_high) begin
      pwr_ctrl_nxt = `AMGC_RST_PWR;
    end else if (reg_wr && reg_addr == `AMGC_OFS_PWR_CTRL) begin
      pwr_ctrl_nxt = reg_wdata & `AMGC_PWR_MASK;
    end
    if (reg_wr && reg_addr == `AMGC_OFS_CONV_PDN) begin
      conv_pdn_nxt = reg_wdata & `AMGC_RST_CPD;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ctrl_r <= `AMGC_RST_PWR;
      conv_pdn_r <= `AMGC_RST_CPD;
    end else begin
      pwr_ctrl_r <= pwr_ctrl_nxt;
      conv_pdn_r <= conv_pdn_nxt;
    end
  end

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_ADC_IN), .MASK(`AMGC_ADC_IN_MASK))
    u_adc_in ( // R03
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_adc),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_ADC_IN),
    .wr_data(reg_wdata),
    .value_r(adc_in_val)
  );

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_MIX), .MASK(`AMGC_MIX_MASK))
    u_dac2 ( // R06
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_dac2),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_DAC2_MIX),
    .wr_data(reg_wdata),
    .value_r(dac2_val)
  );

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_MIX), .MASK(`AMGC_MIX_MASK))
    u_aux1 ( // R07 R10
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_aux),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_AUX1_MIX),
    .wr_data(reg_wdata),
    .value_r(aux1_val)
  );

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_MIX), .MASK(`AMGC_MIX_MASK))
    u_aux2 ( // R08 R10
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_aux),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_AUX2_MIX),
    .wr_data(reg_wdata),
    .value_r(aux2_val)
  );

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_MIX), .MASK(`AMGC_MIX_MASK))
    u_aux3 ( // R09 R10
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_aux),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_AUX3_MIX),
    .wr_data(reg_wdata),
    .value_r(aux3_val)
  );

  amgc_mix_reg #(.RST_VAL(`AMGC_RST_MIX), .MASK(`AMGC_MIX_MASK))
    u_mic ( // R14
    .clk(clk),
    .rst_b(rst_b),
    .hold(hold_aux),
    .wr_en(reg_wr && reg_addr == `AMGC_OFS_MIC_MIX),
    .wr_data(reg_wdata),
    .value_r(mic_val)
  );

  // Read mux; reserved bits are already zero in storage
  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_addr == `AMGC_OFS_STATUS) begin
      rdata_nxt[`AMGC_PDN_FLAG_BIT] = conv_pdn; // R15
    end else if (reg_addr == `AMGC_OFS_ADC_IN) begin
      rdata_nxt = adc_in_val;
    end else if (reg_addr == `AMGC_OFS_DAC2_MIX) begin
      rdata_nxt = dac2_val;
    end else if (reg_addr == `AMGC_OFS_AUX1_MIX) begin
      rdata_nxt = aux1_val;
    end else if (reg_addr == `AMGC_OFS_AUX2_MIX) begin
      rdata_nxt = aux2_val;
    end else if (reg_addr == `AMGC_OFS_AUX3_MIX) begin
      rdata_nxt = aux3_val;
    end else if (reg_addr == `AMGC_OFS_MIC_MIX) begin
      rdata_nxt = mic_val;
    end else if (reg_addr == `AMGC_OFS_PWR_CTRL) begin
      rdata_nxt = pwr_ctrl_r;
    end else if (reg_addr == `AMGC_OFS_CONV_PDN) begin
      rdata_nxt = conv_pdn_r;
    end
  end

  // Field outputs are registered copies; they trail storage by one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 16'h0000;
      converter_powered_down_flag_r <= 1'b1;
      right_adc_mic_boost_r <= 1'b0;
      right_adc_input_gain_r <= 4'h0;
      left_dac2_mix_mute_r <= 1'b1;
      left_dac2_mix_gain_r <= 5'h08;
      right_dac2_mix_mute_r <= 1'b1;
      right_dac2_mix_gain_r <= 5'h08;
      left_aux1_mix_mute_r <= 1'b1;
      left_aux1_mix_gain_r <= 5'h08;
      right_aux1_mix_mute_r <= 1'b1;
      right_aux1_mix_gain_r <= 5'h08;
      left_aux2_mix_mute_r <= 1'b1;
      left_aux2_mix_gain_r <= 5'h08;
      right_aux2_mix_mute_r <= 1'b1;
      right_aux2_mix_gain_r <= 5'h08;
      left_aux3_mix_mute_r <= 1'b1;
      left_aux3_mix_gain_r <= 5'h08;
      right_aux3_mix_mute_r <= 1'b1;
      right_aux3_mix_gain_r <= 5'h08;
      left_mic_mix_mute_r <= 1'b1;
      left_mic_mix_gain_r <= 5'h08;
      right_mic_mix_mute_r <= 1'b1;
      right_mic_mix_gain_r <= 5'h08;
    end else begin
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end else begin
        reg_rdata_r <= 16'h0000;
      end
      converter_powered_down_flag_r <= conv_pdn; // R15
      right_adc_mic_boost_r <= adc_in_val[4]; // R01
      right_adc_input_gain_r <= adc_in_val[3:0]; // R02
      left_dac2_mix_mute_r <= dac2_val[15]; // R04
      left_dac2_mix_gain_r <= dac2_val[12:8]; // R04 R05
      right_dac2_mix_mute_r <= dac2_val[7]; // R04
      right_dac2_mix_gain_r <= dac2_val[4:0]; // R04 R05
      left_aux1_mix_mute_r <= aux1_val[15]; // R07
      left_aux1_mix_gain_r <= aux1_val[12:8]; // R07
      right_aux1_mix_mute_r <= aux1_val[7]; // R07
      right_aux1_mix_gain_r <= aux1_val[4:0]; // R07
      left_aux2_mix_mute_r <= aux2_val[15]; // R08
      left_aux2_mix_gain_r <= aux2_val[12:8]; // R08
      right_aux2_mix_mute_r <= aux2_val[7]; // R08
      right_aux2_mix_gain_r <= aux2_val[4:0]; // R08
      left_aux3_mix_mute_r <= aux3_val[15]; // R09
      left_aux3_mix_gain_r <= aux3_val[12:8]; // R09
      right_aux3_mix_mute_r <= aux3_val[7]; // R09
      right_aux3_mix_gain_r <= aux3_val[4:0]; // R09
      left_mic_mix_mute_r <= mic_val[15]; // R11
      left_mic_mix_gain_r <= mic_val[12:8]; // R11 R12
      right_mic_mix_mute_r <= mic_val[7]; // R11
      right_mic_mix_gain_r <= mic_val[4:0]; // R11 R12
    end
  end
endmodule // amgc_bank

// ---- amgc_bank_sva.sv ----
// Assertion checker for the mixer gain register bank
`timescale 1ns/1ps
module amgc_bank_sva (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Pin and register port
  input wire power_down_pin_b,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_r,
  // Outputs watched
  input wire converter_powered_down_flag_r,
  input wire right_adc_mic_boost_r,
  input wire [3:0] right_adc_input_gain_r,
  input wire left_dac2_mix_mute_r,
  input wire [4:0] left_dac2_mix_gain_r
);
  wire flg;
  wire [4:0] a;
  assign flg = converter_powered_down_flag_r;
  assign a = reg_addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_flag_pin: assert property (!power_down_pin_b [*8] |-> flg)
    else $error("flag low with pin low");
  // Four cycles leave room for the field stage, which trails the flag by one cycle
  chk_adc_held: assert property (flg [*4] |->
    !right_adc_mic_boost_r && right_adc_input_gain_r == 4'h0)
    else $error("adc fields not default");
  chk_dac2_held: assert property (flg [*4] |->
    left_dac2_mix_mute_r && left_dac2_mix_gain_r == 5'h08)
    else $error("dac2 fields not default");
  // Read data and flag both take the power-down state at the read edge
  chk_status_read: assert property (reg_rd && a == 5'h00 |=>
    reg_rdata_r == {1'b0, flg, 14'h0000})
    else $error("status read wrong");
  chk_mix_rsv: assert property (reg_rd && a >= 5'h03 && a <= 5'h07 |=>
    (reg_rdata_r & 16'h6060) == 16'h0000)
    else $error("mix reserved bits set");
  chk_adc_rsv: assert property (reg_rd && a == 5'h02 |=>
    reg_rdata_r[15:5] == 11'h000)
    else $error("adc reserved bits set");
  chk_unmapped_zero: assert property (reg_rd && (a == 5'h01 ||
    (a >= 5'h08 && a <= 5'h1a) || a >= 5'h1d) |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  chk_gain_cause: assert property ($changed(left_dac2_mix_gain_r) |->
    $past(reg_wr, 2) || $past(reg_wr, 3) || flg || $past(flg))
    else $error("dac2 gain moved alone");
  cov_dac2_wr: cover property (reg_wr && a == 5'h03);
  cov_flag_drop: cover property (flg ##1 !flg);
  cov_mic_rd: cover property (reg_rd && a == 5'h07);
endmodule // amgc_bank_sva

bind amgc_bank amgc_bank_sva u_sva (.clk, .rst_b, .power_down_pin_b,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata_r, .converter_powered_down_flag_r,
  .right_adc_mic_boost_r, .right_adc_input_gain_r, .left_dac2_mix_mute_r,
  .left_dac2_mix_gain_r);

// ---- amgc_mix_reg.v ----
// One 16-bit gain register with hold-at-default and masked storage
`timescale 1ns/1ps
module amgc_mix_reg #(
  parameter [15:0] RST_VAL = 16'h8888,
  parameter [15:0] MASK = 16'h9f9f
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Write side
  input wire hold,
  input wire wr_en,
  input wire [15:0] wr_data,
  // Stored value
  output reg [15:0] value_r
);
  reg [15:0] value_nxt;
  always @* begin
    value_nxt = value_r;
    if (hold) begin
      value_nxt = RST_VAL; // R16
    end else if (wr_en) begin
      value_nxt = wr_data & MASK; // R17
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_r <= RST_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule // amgc_mix_reg

// ---- amgc_regs.vh ----
// Register offsets, field layout, reset values and behaviour list
// Overview of operation
// R01: Right ADC mic boost bit: 0 gives 0 dB, 1 gives +20 dB.
// R02: Right ADC input gain is four bits, 1.5 dB per step up.
// R03: ADC input register resets to 0000, held there under reset or power-down.
// R04: DAC2 mix: left mute 15, left gain 12..8, right mute 7, gain 4..0.
// R05: Mix gain codes step 1.5 dB: 00000 +12, 01000 0, 11111 -34.5 dB.
// R06: DAC2 mix resets 8888, held while power-down or any DAC2 path enable low.
// R07: Aux 1 mix uses the same layout as the DAC2 mix register.
// R08: Aux 2 mix has mute and 5-bit gain per channel, same layout.
// R09: Aux 3 mix has mute and 5-bit gain per channel, same layout.
// R10: Aux mix registers reset 8888, held while power-down or analog mix off.
// R11: Mic mix holds mutes at bits 15 and 7, gains at 12..8 and 4..0.
// R12: Mic mix gains use the common 1.5 dB attenuation coding.
// R13: Software writes zero into reserved bit positions.
// R14: Mic mix resets 8888, held under the same conditions as aux registers.
// R15: Converter powered-down flag is set when the pin is low or request set.
// R16: Writes to a held register are dropped silently, default kept.
// R17: Reserved bits always read back as zero.
`ifndef AMGC_REGS_VH
`define AMGC_REGS_VH
`define AMGC_ADDR_W 5
`define AMGC_OFS_STATUS 5'h00
`define AMGC_OFS_ADC_IN 5'h02
`define AMGC_OFS_DAC2_MIX 5'h03
`define AMGC_OFS_AUX1_MIX 5'h04
`define AMGC_OFS_AUX2_MIX 5'h05
`define AMGC_OFS_AUX3_MIX 5'h06
`define AMGC_OFS_MIC_MIX 5'h07
`define AMGC_OFS_PWR_CTRL 5'h1b
`define AMGC_OFS_CONV_PDN 5'h1c
`define AMGC_RST_MIX 16'h8888
`define AMGC_RST_ADC_IN 16'h0000
`define AMGC_MIX_MASK 16'h9f9f
`define AMGC_ADC_IN_MASK 16'h001f
`define AMGC_PDN_FLAG_BIT 14
`define AMGC_PWR_DDM_BIT 0
`define AMGC_PWR_DA2_BIT 1
`define AMGC_PWR_ANA_BIT 2
`define AMGC_PWR_AAM_BIT 3
`define AMGC_PWR_MASK 16'h000f
`define AMGC_RST_PWR 16'h0000
`define AMGC_CPD_BIT 15
`define AMGC_RST_CPD 16'h8000
`endif

// ---- amgc_sync.v ----
// Three-stage synchroniser with agreement filter for an outside pin
`timescale 1ns/1ps
module amgc_sync (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Pin in and filtered level out
  input wire pin_in,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Level only follows once the two later stages agree
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // amgc_sync

// ---- testbench.sv ----
// Self-checking bench for the mixer gain register bank
`timescale 1ns/1ps
module testbench;
  reg clk;
  reg rst_b;
  reg pin_b;
  reg wr;
  reg rd;
  reg [4:0] adr;
  reg [15:0] wd;
  reg [15:0] v;
  wire [15:0] rdt;
  wire flg;
  wire bst;
  wire [3:0] ig;
  // Mix fields, twelve bits a register, DAC2 at the bottom
  wire [59:0] fl;
  integer num_errors = 0;
  integer tests_run = 0;
  integer a;
  integer b;
  integer i;
  amgc_bank dut (.clk(clk), .rst_b(rst_b), .power_down_pin_b(pin_b),
    .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_r(rdt), .converter_powered_down_flag_r(flg),
    .right_adc_mic_boost_r(bst), .right_adc_input_gain_r(ig),
    .left_dac2_mix_mute_r(fl[11]), .left_dac2_mix_gain_r(fl[10:6]),
    .right_dac2_mix_mute_r(fl[5]), .right_dac2_mix_gain_r(fl[4:0]),
    .left_aux1_mix_mute_r(fl[23]), .left_aux1_mix_gain_r(fl[22:18]),
    .right_aux1_mix_mute_r(fl[17]), .right_aux1_mix_gain_r(fl[16:12]),
    .left_aux2_mix_mute_r(fl[35]), .left_aux2_mix_gain_r(fl[34:30]),
    .right_aux2_mix_mute_r(fl[29]), .right_aux2_mix_gain_r(fl[28:24]),
    .left_aux3_mix_mute_r(fl[47]), .left_aux3_mix_gain_r(fl[46:42]),
    .right_aux3_mix_mute_r(fl[41]), .right_aux3_mix_gain_r(fl[40:36]),
    .left_mic_mix_mute_r(fl[59]), .left_mic_mix_gain_r(fl[58:54]),
    .right_mic_mix_mute_r(fl[53]), .right_mic_mix_gain_r(fl[52:48]));
  task chk(input [15:0] s, input [15:0] e, input string n);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected %s exp %h got %h", n, e, s);
      end
    end
  endtask
  task w(input [4:0] ad, input [15:0] d);
    begin
      @(posedge clk);
      adr <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task r(input [4:0] ad, input [15:0] e);
    begin
      @(posedge clk);
      adr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdt, e, "rdata");
    end
  endtask
  task fchk(input integer k, input [15:0] e);
    chk({4'h0, fl[12*(k-3) +: 12]}, {4'h0, e[15], e[12:8], e[7], e[4:0]},
      "fields");
  endtask
  task wait_flag(input e);
    begin
      // Look a little after the edge so the flag has settled
      #1;
      for (i = 0; i < 40 && flg !== e; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      chk({15'h0000, flg}, {15'h0000, e}, "flag");
      if (flg !== e)
        close_out;
    end
  endtask
  task close_out;
    begin
      if (num_errors == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Covers the end codes and the 0 dB code of the gain fields
  function [15:0] pat(input integer k);
    case (k)
      3: pat = 16'h0000;
      4: pat = 16'h9f08;
      5: pat = 16'h081f;
      6: pat = 16'h8a15;
      default: pat = 16'h1f80;
    endcase
  endfunction
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    pin_b = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    adr = 5'h00;
    wd = 16'h0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    r(5'h00, 16'h4000);
    r(5'h02, 16'h0000);
    for (a = 3; a < 8; a = a + 1) begin
      w(a[4:0], 16'h0000);
      r(a[4:0], 16'h8888);
      fchk(a, 16'h8888);
    end
    w(5'h1c, 16'h0000);
    w(5'h1b, 16'h000f);
    wait_flag(1'b0);
    for (a = 3; a < 8; a = a + 1) begin
      w(a[4:0], 16'hffff);
      r(a[4:0], 16'h9f9f);
      w(a[4:0], pat(a));
      r(a[4:0], pat(a));
      fchk(a, pat(a));
    end
    w(5'h02, 16'hffff);
    r(5'h02, 16'h001f);
    chk({11'h000, bst, ig}, 16'h001f, "adc_fields");
    w(5'h02, 16'h0010);
    r(5'h02, 16'h0010);
    chk({11'h000, bst, ig}, 16'h0010, "adc_fields");
    // Clear one path enable at a time and see which registers hold
    for (b = 0; b < 4; b = b + 1) begin
      w(5'h1b, 16'h000f & ~(16'h0001 << b));
      for (a = 3; a < 8; a = a + 1) begin
        w(a[4:0], 16'h0000);
        v = ((a == 3) ? (b < 3) : (b > 1)) ? 16'h8888 : 16'h0000;
        r(a[4:0], v);
      end
    end
    w(5'h1b, 16'h000f);
    w(5'h1c, 16'h8000);
    r(5'h00, 16'h4000);
    r(5'h02, 16'h0000);
    r(5'h07, 16'h8888);
    w(5'h1c, 16'h0000);
    wait_flag(1'b0);
    w(5'h03, 16'h0101);
    r(5'h03, 16'h0101);
    @(posedge clk);
    pin_b <= 1'b0;
    wait_flag(1'b1);
    r(5'h03, 16'h8888);
    r(5'h01, 16'h0000);
    w(5'h00, 16'hffff);
    r(5'h00, 16'h4000);
    close_out;
  end
endmodule // testbench
